// ---- button_commissioning_fsm.sv ----
// Button press sequence interpreter with an APB register slave.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "bcf_defines.svh"

////////////////////////////////////////////////////////////////////////////
module button_commissioning_fsm #(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire logic pclk, // 200 MHz clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [3:0] contacts, // button contacts
  input wire logic energy_bar, // energy bar actuation
  output bcf_pkg::tx_req_t tx // telegram request, valid for one cycle
);

  //////////////////////////////////////////////////////////////////////////
  // Press timing.
  logic [31:0] tick_cnt_q;
  logic [12:0] dur_q;
  logic bar_q;
  logic [3:0] pat_q;
  wire tick = (tick_cnt_q == TICK_CYCLES - 1);
  wire press_start = energy_bar & ~bar_q;
  wire release_ev = ~energy_bar & bar_q;
  wire is_long = (dur_q >= `LONG_MS);
  wire is_short2 = (dur_q < `SHORT_MS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_q <= 32'h0;
      dur_q <= 13'h0;
      bar_q <= 1'b0;
      pat_q <= 4'h0;
    end
    else
    begin
      bar_q <= energy_bar;
      tick_cnt_q <= (press_start || tick) ? 32'h0 : tick_cnt_q + 32'h1;
      if (press_start)
        dur_q <= 13'h0;
      else if (energy_bar && tick && !is_long)
        dur_q <= dur_q + 13'h1;
      if (press_start)
        pat_q <= contacts;
      else if (energy_bar)
        pat_q <= pat_q | contacts;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State and configuration.
  bcf_pkg::state_t st_q, st_d;
  logic [4:0] chan_q, chan_d, sel_q, sel_d, pend_q, pend_d, prev_q, prev_d;
  logic [3:0] x_q, x_d, last_q, last_d, cfg_q, cfg_d;
  logic first_q, first_d;
  bcf_pkg::tx_req_t tx_d;

  wire dir_en = cfg_q[`CB_DIRECT];
  wire seq_en = cfg_q[`CB_SEQ];
  wire prim = cfg_q[`CB_PRIMARY];
  wire lock = cfg_q[`CB_LOCK];
  wire single = (pat_q == `PAT_A0) || (pat_q == `PAT_AI) ||
                (pat_q == `PAT_B0) || (pat_q == `PAT_BI);
  wire same = (pat_q == x_q);
  wire abort = release_ev && !is_long && single && (last_q != 4'h0) &&
               (last_q != pat_q);

  function automatic logic [4:0] direct_ch(input logic [3:0] p);
    unique case (p)
      `PAT_A0: direct_ch = `CH_15;
      `PAT_AI: direct_ch = `CH_20;
      `PAT_BI: direct_ch = `CH_25;
      default: direct_ch = `CH_FIRST;
    endcase
  endfunction : direct_ch

  function automatic logic [4:0] next_ch(input logic [4:0] c,
                                         input logic p);
    if (p)
      next_ch = (c == `CH_FIRST) ? `CH_15 : (c == `CH_15) ? `CH_20 :
                (c == `CH_20) ? `CH_25 : `CH_FIRST;
    else
      next_ch = (c >= `CH_LAST) ? `CH_FIRST : c + 5'h01;
  endfunction : next_ch

  function automatic bcf_pkg::tx_req_t mk(input bcf_pkg::tx_kind_t k,
                                          input logic [4:0] c,
                                          input logic [3:0] p);
    mk.valid = 1'b1;
    mk.kind = k;
    mk.channel = c;
    mk.contacts = p;
  endfunction : mk

  //////////////////////////////////////////////////////////////////////////
  // APB decode.
  wire setup = psel & ~penable;
  wire hit_ctrl = (paddr == `REG_CTRL);
  wire hit_stat = (paddr == `REG_STATUS);
  wire apb_wr = psel & penable & pwrite & pready & hit_ctrl;
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, cfg_q} :
                       hit_stat ? {11'h0, sel_q, 5'h0, st_q, 3'h0, chan_q} :
                       32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~hit_ctrl & ~hit_stat;
      prdata <= setup ? rd_mux : 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Press interpreter.
  always_comb
  begin
    st_d = st_q;
    chan_d = chan_q;
    sel_d = sel_q;
    pend_d = pend_q;
    prev_d = prev_q;
    x_d = x_q;
    first_d = first_q;
    last_d = last_q;
    cfg_d = cfg_q;
    tx_d = '0;
    if (apb_wr)
      cfg_d = pwdata[3:0];
    if (press_start)
    begin
      if (st_q == bcf_pkg::ST_DIR_WAIT && contacts == `PAT_CONFIRM)
      begin
        prev_d = chan_q;
        chan_d = lock ? chan_q : pend_q;
        st_d = bcf_pkg::ST_CONFIRM;
        tx_d = mk(bcf_pkg::TX_DATA, chan_d, contacts);
      end
    end
    else if (release_ev)
    begin
      last_d = (single && !is_long) ? pat_q : 4'h0;
      tx_d = mk(bcf_pkg::TX_DATA, chan_q, pat_q);
      if (st_q == bcf_pkg::ST_CONFIRM)
      begin
        st_d = bcf_pkg::ST_NORMAL;
        if (prev_q != chan_q)
          tx_d = mk(bcf_pkg::TX_DECOMM, prev_q, pat_q);
      end
      else if (is_long && pat_q == `PAT_RESET)
      begin
        tx_d = mk(bcf_pkg::TX_DECOMM, chan_q, pat_q);
        chan_d = `CH_FIRST;
        cfg_d = `CTRL_RESET;
        st_d = bcf_pkg::ST_NORMAL;
      end
      else if (is_long && pat_q == `PAT_NOCOMM)
      begin
        cfg_d[`CB_DIRECT] = 1'b0;
        cfg_d[`CB_SEQ] = 1'b0;
        st_d = bcf_pkg::ST_NORMAL;
      end
      else if (is_long && pat_q == `PAT_LOCK)
      begin
        cfg_d[`CB_LOCK] = 1'b1;
        st_d = bcf_pkg::ST_NORMAL;
      end
      else if (is_long && pat_q == `PAT_NOSEQ)
      begin
        cfg_d[`CB_SEQ] = 1'b0;
        st_d = bcf_pkg::ST_NORMAL;
      end
      else if (st_q == bcf_pkg::ST_SEQ)
      begin
        if (same && !is_long)
        begin
          sel_d = lock ? chan_q : first_q ? `CH_FIRST : next_ch(sel_q, prim);
          first_d = 1'b0;
          tx_d = mk(bcf_pkg::TX_COMM, sel_d, pat_q);
        end
        else
        begin
          chan_d = lock ? chan_q : sel_q;
          st_d = bcf_pkg::ST_NORMAL;
          tx_d = mk(bcf_pkg::TX_DATA, chan_d, pat_q);
        end
      end
      else if (st_q == bcf_pkg::ST_SHORT)
      begin
        st_d = bcf_pkg::ST_NORMAL;
        if (same && is_long && seq_en)
        begin
          st_d = bcf_pkg::ST_SEQ;
          sel_d = chan_q;
          first_d = 1'b1;
          tx_d = mk(bcf_pkg::TX_COMM, chan_q, pat_q);
        end
      end
      else if (st_q == bcf_pkg::ST_LONG1 && same && !is_long)
        st_d = is_short2 ? bcf_pkg::ST_SHORT : bcf_pkg::ST_NORMAL;
      else if (is_long && (single || pat_q == 4'h0))
      begin
        st_d = bcf_pkg::ST_NORMAL;
        if (dir_en)
        begin
          pend_d = direct_ch(pat_q);
          st_d = bcf_pkg::ST_DIR_WAIT;
          tx_d = mk(bcf_pkg::TX_COMM, lock ? chan_q : pend_d, pat_q);
        end
        if (seq_en && single)
        begin
          st_d = bcf_pkg::ST_LONG1;
          x_d = pat_q;
        end
      end
      else
        st_d = bcf_pkg::ST_NORMAL;
      if (abort)
        st_d = bcf_pkg::ST_NORMAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= bcf_pkg::ST_NORMAL;
      chan_q <= `CH_FIRST;
      sel_q <= `CH_FIRST;
      pend_q <= `CH_FIRST;
      prev_q <= `CH_FIRST;
      x_q <= 4'h0;
      last_q <= 4'h0;
      first_q <= 1'b0;
      cfg_q <= `CTRL_RESET;
      tx <= '0;
    end
    else
    begin
      st_q <= st_d;
      chan_q <= chan_d;
      sel_q <= sel_d;
      pend_q <= pend_d;
      prev_q <= prev_d;
      x_q <= x_d;
      last_q <= last_d;
      first_q <= first_d;
      cfg_q <= cfg_d;
      tx <= tx_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire rel_norm = release_ev && st_q != bcf_pkg::ST_CONFIRM && is_long;

  AST_RESET_CHAN: assert property (
    rel_norm && pat_q == `PAT_RESET |=> chan_q == `CH_FIRST &&
      tx.valid && tx.kind == bcf_pkg::TX_DECOMM &&
      tx.channel == $past(chan_q))
    else $error("factory reset did not decommission and return to 11");
  AST_RESET_CFG: assert property (
    rel_norm && pat_q == `PAT_RESET |=> cfg_q == `CTRL_RESET)
    else $error("factory reset did not restore the settings");
  AST_NOCOMM: assert property (
    rel_norm && pat_q == `PAT_NOCOMM && !apb_wr
      |=> !cfg_q[`CB_DIRECT] && !cfg_q[`CB_SEQ])
    else $error("three-contact gesture left commissioning enabled");
  AST_LOCK: assert property (
    rel_norm && pat_q == `PAT_LOCK && !apb_wr |=> cfg_q[`CB_LOCK] ##1
      (st_q == bcf_pkg::ST_NORMAL))
    else $error("channel lock gesture had no effect");
  AST_NOSEQ: assert property (
    rel_norm && pat_q == `PAT_NOSEQ && !apb_wr |=> !cfg_q[`CB_SEQ])
    else $error("sequential commissioning stayed enabled");
  AST_CONFIRM_PRESS: assert property (
    press_start && st_q == bcf_pkg::ST_DIR_WAIT && contacts == `PAT_CONFIRM
      |=> st_q == bcf_pkg::ST_CONFIRM && tx.kind == bcf_pkg::TX_DATA &&
      tx.channel == chan_q)
    else $error("confirm pair did not adopt the channel");
  AST_CONFIRM_REL: assert property (
    release_ev && st_q == bcf_pkg::ST_CONFIRM && prev_q != chan_q
      |=> tx.kind == bcf_pkg::TX_DECOMM && tx.channel == $past(prev_q))
    else $error("no decommission on the old channel");
  AST_SEQ_ENTRY: assert property (
    release_ev && st_q == bcf_pkg::ST_SHORT && same && is_long && seq_en
      |=> st_q == bcf_pkg::ST_SEQ && tx.kind == bcf_pkg::TX_COMM &&
      tx.channel == chan_q)
    else $error("long-short-long did not enter sequential mode");
  AST_DIRECT: assert property (
    rel_norm && st_q == bcf_pkg::ST_NORMAL && pat_q == `PAT_A0 &&
      dir_en && !lock |=> tx.kind == bcf_pkg::TX_COMM &&
      tx.channel == `CH_15)
    else $error("direct commissioning used the wrong channel");
  AST_ABORT: assert property (
    release_ev && st_q == bcf_pkg::ST_LONG1 && same && !is_short2 &&
      !is_long |=> st_q == bcf_pkg::ST_NORMAL)
    else $error("mid-length press did not abort the sequence");
  AST_STEP_FIRST: assert property (
    release_ev && st_q == bcf_pkg::ST_SEQ && same && !is_long && first_q &&
      !lock |=> sel_q == `CH_FIRST && tx.kind == bcf_pkg::TX_COMM)
    else $error("first step did not select channel 11");

endmodule : button_commissioning_fsm

// ---- bcf_defines.svh ----
// Named constants for the button commissioning interpreter.
`ifndef BCF_DEFINES_SVH
`define BCF_DEFINES_SVH
`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000000
`define LONG_MS 13'h1B58
`define SHORT_MS 13'h07D0
`define CH_FIRST 5'h0B
`define CH_LAST 5'h1A
`define CH_15 5'h0F
`define CH_20 5'h14
`define CH_25 5'h19
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define CTRL_RESET 4'h2
`define CB_DIRECT 0
`define CB_SEQ 1
`define CB_PRIMARY 2
`define CB_LOCK 3
`define PAT_A0 4'h1
`define PAT_AI 4'h2
`define PAT_B0 4'h4
`define PAT_BI 4'h8
`define PAT_CONFIRM 4'h6
`define PAT_NOSEQ 4'hC
`define PAT_NOCOMM 4'hB
`define PAT_LOCK 4'hE
`define PAT_RESET 4'hF
`endif

// ---- bcf_pkg.sv ----
// Types shared by the button commissioning interpreter.
package bcf_pkg;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_LONG1 = 3'b001,
    ST_SHORT = 3'b010,
    ST_SEQ = 3'b011,
    ST_DIR_WAIT = 3'b100,
    ST_CONFIRM = 3'b101
  } state_t;
  typedef enum logic [1:0] {
    TX_NONE = 2'b00,
    TX_DATA = 2'b01,
    TX_COMM = 2'b10,
    TX_DECOMM = 2'b11
  } tx_kind_t;
  typedef struct packed {
    logic valid;
    tx_kind_t kind;
    logic [4:0] channel;
    logic [3:0] contacts;
  } tx_req_t;
endpackage : bcf_pkg

// ---- radio_sink.sv ----
// Radio transmitter model that takes each telegram request.
`timescale 1ns/10ps
module radio_sink (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire bcf_pkg::tx_req_t tx, // telegram request
  output logic got, // a telegram was taken
  output bcf_pkg::tx_req_t got_tx // the telegram taken
);
  // The transmitter latches a request in the cycle its valid bit stands.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      got <= 1'b0;
      got_tx <= '0;
    end
    else
    begin
      got <= tx.valid;
      got_tx <= tx;
    end
endmodule : radio_sink

// ---- button_commissioning_fsm_bench.sv ----
// Self-checking bench for the button commissioning interpreter.
`timescale 1ns/10ps
`include "bcf_defines.svh"
module button_commissioning_fsm_bench;
  localparam int TK = 1;
  localparam int LONG = 7000 * TK + 40;
  localparam int MID = 3000 * TK;
  typedef struct packed {logic chk; bcf_pkg::tx_req_t t;} note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] contacts = 4'h0;
  logic energy_bar = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, got;
  bcf_pkg::tx_req_t tx, got_tx;
  note_t q[$];
  note_t cur;
  int err_total = 0;
  int samples_checked = 0;

  always #2.5 pclk = ~pclk;

  button_commissioning_fsm #(.TICK_CYCLES(TK)) button_commissioning_fsm_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .contacts(contacts),
    .energy_bar(energy_bar), .tx(tx));
  radio_sink radio_sink_inst (.pclk(pclk), .presetn(presetn), .tx(tx),
    .got(got), .got_tx(got_tx));

  ////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task expect_tx(input logic c, input bcf_pkg::tx_kind_t k,
                 input logic [4:0] ch, input logic [3:0] ct);
    q.push_back(note_t'({c, 1'b1, k, ch, ct}));
  endtask : expect_tx

  // One actuation: contacts and energy bar go down and up together.
  task press(input logic [3:0] c, input int len);
    @(posedge pclk);
    energy_bar <= 1'b1;
    contacts <= c;
    repeat (len) @(posedge pclk);
    energy_bar <= 1'b0;
    contacts <= 4'h0;
    repeat (30) @(posedge pclk);
  endtask : press

  function int shortp;
    return 20 + $urandom_range(300);
  endfunction : shortp

  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
    if (got === 1'b1)
    begin
      if (q.size() == 0)
        chk("unexpected telegram", 32'h0, 32'h1);
      else
      begin
        cur = q.pop_front();
        if (cur.chk)
          chk("telegram", 32'(cur.t), 32'(got_tx));
      end
    end

  initial
  begin
    // Twelve long presses and the rest take about 92,000 cycles at most.
    repeat (96000) @(posedge pclk);
    chk("watchdog", 32'h0, 32'h1);
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(32'h1501F7DB));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl reset", 32'(`CTRL_RESET), rd);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("channel reset", 32'(`CH_FIRST), 32'(rd[4:0]));
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    apb(1'b1, `REG_CTRL, ($urandom & 32'hFFFFFFF0) | 32'h1);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl written", 32'h1, rd);
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_15, `PAT_A0);
    press(`PAT_A0, LONG);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_15, `PAT_CONFIRM);
    expect_tx(1'b1, bcf_pkg::TX_DECOMM, `CH_FIRST, `PAT_CONFIRM);
    press(`PAT_CONFIRM, shortp());
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("adopted channel", 32'(`CH_15), 32'(rd[4:0]));
    apb(1'b1, `REG_CTRL, 32'h2);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_15, `PAT_B0);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_15, `PAT_B0);
    press(`PAT_B0, LONG);
    press(`PAT_B0, shortp());
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_15, `PAT_B0);
    press(`PAT_B0, LONG);
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_FIRST, `PAT_B0);
    press(`PAT_B0, shortp());
    expect_tx(1'b1, bcf_pkg::TX_COMM, 5'h0C, `PAT_B0);
    press(`PAT_B0, shortp());
    expect_tx(1'b1, bcf_pkg::TX_DATA, 5'h0C, `PAT_A0);
    press(`PAT_A0, shortp());
    apb(1'b1, `REG_CTRL, 32'h0);
    expect_tx(1'b1, bcf_pkg::TX_DATA, 5'h0C, `PAT_A0);
    press(`PAT_A0, LONG);
    expect_tx(1'b1, bcf_pkg::TX_DECOMM, 5'h0C, `PAT_RESET);
    press(`PAT_RESET, LONG);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl after reset", 32'h2, rd);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("channel after reset", 32'(`CH_FIRST), 32'(rd[4:0]));
    // Both modes with primary stepping: abort, entry, steps and confirm.
    apb(1'b1, `REG_CTRL, 32'h7);
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_20, `PAT_AI);
    press(`PAT_AI, LONG);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_FIRST, `PAT_AI);
    press(`PAT_AI, MID);
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_20, `PAT_AI);
    press(`PAT_AI, LONG);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_FIRST, `PAT_AI);
    press(`PAT_AI, shortp());
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_FIRST, `PAT_AI);
    press(`PAT_AI, LONG);
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_FIRST, `PAT_AI);
    press(`PAT_AI, shortp());
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_15, `PAT_AI);
    press(`PAT_AI, shortp());
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_20, `PAT_AI);
    press(`PAT_AI, shortp());
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_20, `PAT_B0);
    press(`PAT_B0, shortp());
    // Lock gesture, locked direct commissioning and an unchanged confirm.
    apb(1'b1, `REG_CTRL, 32'h1);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_20, `PAT_LOCK);
    press(`PAT_LOCK, LONG);
    expect_tx(1'b1, bcf_pkg::TX_COMM, `CH_20, `PAT_A0);
    press(`PAT_A0, LONG);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_20, `PAT_CONFIRM);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_20, `PAT_CONFIRM);
    press(`PAT_CONFIRM, shortp());
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl locked", 32'h9, rd);
    // Gestures that disable the commissioning modes.
    apb(1'b1, `REG_CTRL, 32'h3);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_20, `PAT_NOSEQ);
    press(`PAT_NOSEQ, LONG);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl no sequential", 32'h1, rd);
    expect_tx(1'b1, bcf_pkg::TX_DATA, `CH_20, `PAT_NOCOMM);
    press(`PAT_NOCOMM, LONG);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl no commissioning", 32'h0, rd);
    repeat (20) @(posedge pclk);
    chk("pending telegrams", 32'h0, 32'(q.size()));
    tally_and_finish();
  end
endmodule : button_commissioning_fsm_bench
